// ===== logic/ess_pkg.sv
// ess_pkg: shared types and constants for the emergency stop sequencer
// assumes: one 10 MHz clock, all delays given in clock ticks by the user side
package ess_pkg;
  // ---------------------------------------------------------------
  // widths and constants
  // ---------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int SPD_W = 16;
  localparam int CLK_HZ = 10000000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  // sequencer states
  typedef enum logic [2:0] {
    ESS_IDLE,
    ESS_RAMP,
    ESS_XDELAY,
    ESS_BRAKE_LEAD,
    ESS_BRAKE_WAIT,
    ESS_DONE
  } ess_state_e;

  // configuration bundle
  typedef struct packed {
    logic ramp_mode;                 // 1: ramp monitored, 0: time monitored
    logic brake_en;                  // brake_control part of torque removal
    logic signed [CNT_W:0] signed_brake_delay;
    logic [CNT_W-1:0] brake_time_to_zero;
    logic [CNT_W-1:0] extra_torque_off_delay;
    logic [CNT_W-1:0] torque_off_timeout;
    logic [SPD_W-1:0] zero_speed_threshold;
    logic [SPD_W-1:0] ramp_limit_first;   // lower speed envelope
    logic [SPD_W-1:0] ramp_limit_second;  // upper speed envelope
  } ess_cfg_s;

  // indications towards the drive and user
  typedef struct packed {
    logic stop_active_indication;
    logic stop_completed_indication;
    logic torque_off_indication;
    logic torque_removal;
    logic brake_control;
    logic ramp_request;
  } ess_out_s;
endpackage

// ===== logic/ess_timer.sv
// ess_timer: loadable down counter, pulses done when a loaded count expires
// assumes: start is a one-cycle pulse from logic on the same clock
module ess_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic clear,
  input wire logic [W-1:0] load,
  // status
  output logic done,
  output logic running
);
  logic [W-1:0] cnt_reg;

  // -----------------------------------------------------------
  // counter
  // -----------------------------------------------------------
  // a zero load expires on the next edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (clear) begin
      cnt_reg <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_reg <= load;
      running <= 1'b1;
      done <= 1'b0;
    end else if (running) begin
      done <= (cnt_reg <= W'(1));
      running <= (cnt_reg > W'(1));
      cnt_reg <= (cnt_reg == '0) ? '0 : cnt_reg - W'(1);
    end else begin
      done <= 1'b0;
    end
  end
endmodule

// ===== logic/ess_sequencer.sv
// ess_sequencer: emergency_stop_function sequencer, time or ramp monitored
// assumes: stop request and acknowledge arrive on pins; speed is a
// magnitude from the drive sampled on mclk; delays are in mclk ticks
// ---------------------------------------------------------------
// Notes on behaviour
// - time mode: zero speed removes torque
// - completed shown; ack only after request removed
// - brake applied with or before torque removal when configured
// - negative delay at zero speed: brake first, torque later
// - non-negative delay: brake and torque together
// - completion waits brake time-to-zero
// - optional extra delay before torque removal
// - timeout forces torque removal, time mode only
// - ack clears function, torque and indications
// - ramp mode: active shown at request
// - ramp checking starts with deceleration
// - ramp limit crossing removes torque at once
// - ramp mode zero speed ends checking
// - ramp mode ack returns drive control
// - zero speed threshold comparison
// - timeout counter starts on request
module ess_sequencer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins from the request source
  input wire logic stop_req_pin,
  input wire logic ack_pin,
  // drive feedback
  input wire logic [ess_pkg::SPD_W-1:0] motor_speed,
  input wire logic decel_started,
  // configuration
  input wire ess_pkg::ess_cfg_s cfg,
  // outputs to drive and user
  output ess_pkg::ess_out_s outs
);
  // -----------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------
  logic [2:0] req_sync_reg;
  logic [2:0] ack_sync_reg;
  logic req_reg;
  logic ack_reg;
  logic ack_prev_reg;
  logic ack_rise;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_sync_reg <= 3'h0;
      ack_sync_reg <= 3'h0;
      req_reg <= 1'b0;
      ack_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], stop_req_pin};
      ack_sync_reg <= {ack_sync_reg[1:0], ack_pin};
      if (req_sync_reg[1] == req_sync_reg[2]) req_reg <= req_sync_reg[2];
      if (ack_sync_reg[1] == ack_sync_reg[2]) ack_reg <= ack_sync_reg[2];
      ack_prev_reg <= ack_reg;
    end
  end

  assign ack_rise = ack_reg & ~ack_prev_reg;

  // -----------------------------------------------------------
  // speed comparisons
  // -----------------------------------------------------------
  logic at_zero;
  logic ramp_fault;
  logic ramp_check_reg;

  assign at_zero = (motor_speed <= cfg.zero_speed_threshold);
  assign ramp_fault = ramp_check_reg &&
                      ((motor_speed < cfg.ramp_limit_first) || (motor_speed > cfg.ramp_limit_second));

  // -----------------------------------------------------------
  // timers
  // -----------------------------------------------------------
  ess_pkg::ess_state_e state_reg;
  logic tmo_start, tmo_done, xd_start, xd_done, bl_start, bl_done, bz_start, bz_done;
  logic tmr_clear;
  logic [ess_pkg::CNT_W-1:0] lead_mag;

  // idle clears the timers, except in the cycle the request is taken,
  // otherwise the clear would swallow the timeout load
  assign tmr_clear = (state_reg == ess_pkg::ESS_IDLE) & ~req_reg;
  assign lead_mag = ess_pkg::CNT_W'(-cfg.signed_brake_delay);

  ess_timer #(.W(ess_pkg::CNT_W)) u_tmo (
    .mclk(mclk), .rst(rst), .start(tmo_start), .clear(tmr_clear),
    .load(cfg.torque_off_timeout), .done(tmo_done), .running()
  );
  ess_timer #(.W(ess_pkg::CNT_W)) u_xd (
    .mclk(mclk), .rst(rst), .start(xd_start), .clear(tmr_clear),
    .load(cfg.extra_torque_off_delay), .done(xd_done), .running()
  );
  ess_timer #(.W(ess_pkg::CNT_W)) u_bl (
    .mclk(mclk), .rst(rst), .start(bl_start), .clear(tmr_clear),
    .load(lead_mag), .done(bl_done), .running()
  );
  ess_timer #(.W(ess_pkg::CNT_W)) u_bz (
    .mclk(mclk), .rst(rst), .start(bz_start), .clear(tmr_clear),
    .load(cfg.brake_time_to_zero), .done(bz_done), .running()
  );

  // -----------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------
  logic force_off;
  logic brake_neg;
  logic zero_hit;
  logic bz_hit_reg;
  logic bz_over;

  // timeout forces removal, time mode only
  assign force_off = (~cfg.ramp_mode & tmo_done) | ramp_fault;
  assign brake_neg = cfg.brake_en & cfg.signed_brake_delay[ess_pkg::CNT_W];
  assign zero_hit = at_zero & (~cfg.ramp_mode | ramp_check_reg | decel_started);
  assign tmo_start = (state_reg == ess_pkg::ESS_IDLE) & req_reg;
  assign xd_start = (state_reg == ess_pkg::ESS_RAMP) & zero_hit & ~force_off;
  assign bl_start = (state_reg == ess_pkg::ESS_XDELAY) & xd_done & brake_neg;
  assign bz_start = cfg.brake_en & ~outs.brake_control &
                    (((state_reg == ess_pkg::ESS_RAMP) & force_off) |
                     ((state_reg == ess_pkg::ESS_XDELAY) & xd_done));

  // brake time expiry remembered
  // a long brake lead may outlast the brake time; keep its expiry
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bz_hit_reg <= 1'b0;
    end else if (bz_done) begin
      bz_hit_reg <= 1'b1;
    end else if (state_reg == ess_pkg::ESS_IDLE) begin
      bz_hit_reg <= 1'b0;
    end
  end

  assign bz_over = bz_done | bz_hit_reg;

  // state transitions
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ess_pkg::ESS_IDLE;
    end else begin
      case (state_reg)
        ess_pkg::ESS_IDLE: begin
          if (req_reg) state_reg <= ess_pkg::ESS_RAMP;
        end
        ess_pkg::ESS_RAMP: begin
          if (force_off) state_reg <= cfg.brake_en ? ess_pkg::ESS_BRAKE_WAIT : ess_pkg::ESS_DONE;
          else if (zero_hit) state_reg <= ess_pkg::ESS_XDELAY;
        end
        ess_pkg::ESS_XDELAY: begin
          if (xd_done) begin
            if (brake_neg) state_reg <= ess_pkg::ESS_BRAKE_LEAD;
            else if (cfg.brake_en) state_reg <= ess_pkg::ESS_BRAKE_WAIT;
            else state_reg <= ess_pkg::ESS_DONE;
          end
        end
        ess_pkg::ESS_BRAKE_LEAD: begin
          if (bl_done) state_reg <= ess_pkg::ESS_BRAKE_WAIT;
        end
        ess_pkg::ESS_BRAKE_WAIT: begin
          if (bz_over) state_reg <= ess_pkg::ESS_DONE;
        end
        ess_pkg::ESS_DONE: begin
          if (ack_rise & ~req_reg) state_reg <= ess_pkg::ESS_IDLE;
        end
        default: state_reg <= ess_pkg::ESS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ramp_check_reg <= 1'b0;
    end else if (state_reg != ess_pkg::ESS_RAMP || !cfg.ramp_mode || at_zero) begin
      ramp_check_reg <= 1'b0;
    end else if (decel_started) begin
      ramp_check_reg <= 1'b1;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  // ack clears all indications
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outs <= '0;
    end else if (state_reg == ess_pkg::ESS_IDLE) begin
      outs <= '0;
      outs.stop_active_indication <= req_reg;
      outs.ramp_request <= req_reg;     // drive told to decelerate
    end else begin
      if (state_reg == ess_pkg::ESS_RAMP && force_off) begin
        outs.torque_removal <= 1'b1;
        outs.torque_off_indication <= 1'b1;
        outs.brake_control <= cfg.brake_en;
        outs.stop_completed_indication <= ~cfg.brake_en;
      end
      if (state_reg == ess_pkg::ESS_XDELAY && xd_done) begin
        outs.brake_control <= cfg.brake_en;
        outs.torque_removal <= ~brake_neg;
        outs.torque_off_indication <= ~brake_neg;
        outs.stop_completed_indication <= ~cfg.brake_en;
      end
      if (state_reg == ess_pkg::ESS_BRAKE_LEAD && bl_done) begin
        outs.torque_removal <= 1'b1;
        outs.torque_off_indication <= 1'b1;
      end
      if (state_reg == ess_pkg::ESS_BRAKE_WAIT && bz_over) outs.stop_completed_indication <= 1'b1;
      if (state_reg == ess_pkg::ESS_DONE && ack_rise && !req_reg) begin
        outs <= '0;
      end
    end
  end
endmodule

// ===== testbench/ess_drive_model.sv
// ess_drive_model: drive that ramps speed down on request
// assumes: ramp_request from the sequencer, same clock
module ess_drive_model (
  // clock, reset
  input wire logic mclk,
  input wire logic rst,
  // from sequencer and bench
  input wire logic ramp_request,
  input wire logic [ess_pkg::SPD_W-1:0] step,
  // feedback
  output logic [ess_pkg::SPD_W-1:0] motor_speed,
  output logic decel_started
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lag;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lag <= 2'h0;
      decel_started <= 1'b0;
      motor_speed <= 16'h3E8;
    end else if (!ramp_request) begin
      lag <= 2'h0;
      decel_started <= 1'b0;
      motor_speed <= 16'h3E8;
    end else if (lag != 2'h3) begin
      lag <= lag + 2'h1;
    end else begin
      decel_started <= 1'b1;
      motor_speed <= (motor_speed > step) ? motor_speed - step : 16'h0;
    end
  end
endmodule

// ===== testbench/ess_monitor.sv
// ess_monitor: checker on the sequencer ports
// assumes: cfg static during a stop
module ess_monitor (
  // clock, reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic stop_req_pin,
  input wire logic ack_pin,
  input wire logic [ess_pkg::SPD_W-1:0] motor_speed,
  input wire logic decel_started,
  input wire ess_pkg::ess_cfg_s cfg,
  input wire ess_pkg::ess_out_s outs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [24:0] brk_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles the brake is held
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brk_cnt <= 25'h0;
    end else begin
      brk_cnt <= outs.brake_control ? brk_cnt + 25'h1 : 25'h0;
    end
  end
  stop_shown_a: assert property (
    stop_req_pin [*6] |-> outs.stop_active_indication) else $error("active missing");
  torque_ind_a: assert property (
    outs.torque_removal == outs.torque_off_indication) else $error("torque ind");
  brake_cfg_a: assert property (
    outs.brake_control |-> cfg.brake_en) else $error("brake unconfigured");
  brake_lead_a: assert property (
    $rose(outs.brake_control) && cfg.signed_brake_delay[24] |-> !outs.torque_removal) else $error("lead");
  brake_sync_a: assert property (
    cfg.brake_en && !cfg.signed_brake_delay[24] && $rose(outs.torque_removal)
    |-> $rose(outs.brake_control)) else $error("brake sync");
  brake_wait_a: assert property (
    $rose(outs.stop_completed_indication) && cfg.brake_en
    |-> brk_cnt >= {1'b0, cfg.brake_time_to_zero}) else $error("early done");
  early_ack_a: assert property (
    stop_req_pin [*6] |-> !$fell(outs.stop_completed_indication)) else $error("ack taken");
  clear_all_a: assert property (
    $fell(outs.stop_completed_indication) |-> outs == 6'h0) else $error("not cleared");
  cover property ($rose(outs.stop_completed_indication));
  cover property ($rose(outs.brake_control) && !outs.torque_removal);
  cover property (cfg.ramp_mode && $rose(outs.torque_removal));
endmodule
bind ess_sequencer ess_monitor u_mon (.mclk(mclk), .rst(rst), .stop_req_pin(stop_req_pin),
  .ack_pin(ack_pin), .motor_speed(motor_speed), .decel_started(decel_started), .cfg(cfg), .outs(outs));

// ===== testbench/test_ess_sequencer.sv
// test_ess_sequencer: directed stop sequences
// assumes: drive model on the far side
module test_ess_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, stop_req_pin, ack_pin, decel_started;
  logic [15:0] motor_speed, step, spd_rem;
  ess_pkg::ess_cfg_s cfg;
  ess_pkg::ess_out_s outs;
  int errors, num_checks, t0, t_act, t_zero, t_brk, t_rem, t_done;
  int cyc = 0;
  ess_sequencer u_dut (.mclk(mclk), .rst(rst), .stop_req_pin(stop_req_pin), .ack_pin(ack_pin),
    .motor_speed(motor_speed), .decel_started(decel_started), .cfg(cfg), .outs(outs));
  ess_drive_model u_drv (.mclk(mclk), .rst(rst), .ramp_request(outs.ramp_request), .step(step),
    .motor_speed(motor_speed), .decel_started(decel_started));
  // clock and cycle count
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // range compare, unknown counts as miss
  task automatic rng(input string nm, input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    num_checks++;
    if ((v >= lo && v <= hi) !== 1'b1) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  task automatic setc(input logic rm, be, input logic [24:0] bd, input logic [23:0] ex, tmo,
    input logic [15:0] lo);
    cfg <= '{ramp_mode: rm, brake_en: be, signed_brake_delay: bd, brake_time_to_zero: 24'hA,
      extra_torque_off_delay: ex, torque_off_timeout: tmo, zero_speed_threshold: 16'hA,
      ramp_limit_first: lo, ramp_limit_second: 16'h7D0};
  endtask
  // raise request, log event cycles until completed
  task automatic run(input logic [15:0] stp);
    int n;
    n = 0;
    step <= stp;
    stop_req_pin <= 1'b1;
    t0 = cyc;
    {t_act, t_zero, t_brk, t_rem} = '0;
    while (outs.stop_completed_indication !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 3000) begin
        errors++;
        print_verdict();
      end
      if (t_act == 0 && outs.stop_active_indication === 1'b1) t_act = cyc;
      if (t_zero == 0 && motor_speed <= 16'hA) t_zero = cyc;
      if (t_brk == 0 && outs.brake_control === 1'b1) t_brk = cyc;
      if (t_rem == 0 && outs.torque_removal === 1'b1) begin
        t_rem = cyc;
        spd_rem = motor_speed;
      end
    end
    t_done = cyc;
    @(posedge mclk);
  endtask
  // ack early, then release and ack
  task automatic release_stop(input int k);
    ack_pin <= 1'b1;
    repeat (2) @(posedge mclk);
    ack_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    rng("early ack", outs.stop_completed_indication, 1, 1);
    stop_req_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    ack_pin <= 1'b1;
    repeat (2) @(posedge mclk);
    ack_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    rng("outs", outs, 0, 0);
    $display("test %0d done", k);
  endtask
  initial begin
    {rst, stop_req_pin, ack_pin, step, cfg} = '0;
    rst = 1'b1;
    {errors, num_checks} = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    setc(1'b0, 1'b0, 25'h0, 24'hC, 24'hBB8, 16'h0);
    run(16'h64);
    rng("extra delay", t_rem - t_zero, 13, 16);
    rng("torque off", outs.torque_off_indication, 1, 1);
    release_stop(1);
    setc(1'b0, 1'b0, 25'h0, 24'h0, 24'h28, 16'h0);
    run(16'h0);
    rng("timeout", t_rem - t0, 41, 50);
    release_stop(2);
    setc(1'b0, 1'b1, 25'h5, 24'h0, 24'hBB8, 16'h0);
    run(16'h64);
    rng("brake sync", t_rem - t_brk, 0, 0);
    rng("brake wait", t_done - t_brk, 10, 13);
    release_stop(3);
    setc(1'b0, 1'b1, 25'h1FFFFFA, 24'h0, 24'hBB8, 16'h0);
    run(16'h64);
    rng("brake lead", t_rem - t_brk, 6, 9);
    rng("brake wait", t_done - t_brk, 10, 13);
    release_stop(4);
    setc(1'b1, 1'b0, 25'h0, 24'h0, 24'hBB8, 16'h352);
    run(16'h64);
    rng("fault speed", spd_rem, 11, 1000);
    release_stop(5);
    setc(1'b1, 1'b0, 25'h0, 24'h0, 24'hBB8, 16'h0);
    run(16'h64);
    rng("active", t_act - t0, 3, 7);
    rng("ramp zero", t_rem - t_zero, 1, 4);
    release_stop(6);
    print_verdict();
  end
endmodule
